// ===== rtl/irqef_top.sv
// module: interrupt enable, request and contactless error flag logic
`timescale 1ns/1ps

// Functional notes
// - bit 7 selects push-pull or open-drain pin
// - bit 6 gates combined interrupt onto pin
// - card detect request gated by bit 5
// - timer n request gated by enable bit n
// - nvm error flag tracks last nvm command
// - fifo write in busy phases sets bit 6
// - fifo write error clears on command start, or on error_flags_stored in multi-frame mode
// - write to full fifo sets overflow, discards
// - sof then under four bits sets bit 4
// - short frames dropped silently, no done request
// - transmit with empty fifo sets bit 3
// - collision sets bit 2, records first position
// - collision inside end-of-frame is ignored
// - protocol faults set bit 1, stop reception
// - byte in flight at protocol fault dropped
// - parity or crc mismatch sets bit 0
// - collision-as-error also sets integrity flag
// - receive flags clear at receive phase start
// - error request follows five error flags: bits 6, 5, 3, 1 and 0
// - combined flag set by any enabled request
// - polarity bit inverts interrupt pin level
// - timer underflow sets its request flag
module irqef_top (
    input  logic                      clk_sys,
    input  logic                      reset_n,
    // host register port
    input  logic [7:0]                reg_addr,
    input  logic [7:0]                reg_wdata,
    input  logic                      reg_wr,
    input  logic                      reg_rd,
    output logic [7:0]                reg_rdata,
    // request sources
    input  logic [4:0]                tmr_underflow,
    input  logic                      card_detect_event,
    input  logic                      nvm_cmd_done,
    input  logic                      nvm_cmd_error,
    // fifo side
    input  logic                      host_fifo_wr,
    input  logic                      fifo_full,
    input  logic                      fifo_empty,
    input  logic                      fifo_flush,
    output logic                      fifo_push,
    // command and transceiver state
    input  logic [2:0]                com_state,
    input  logic                      crc_tx_active,
    input  logic                      auth_active,
    input  logic                      cl_cmd_start,
    input  logic                      rx_cmd_start,
    input  logic                      wait_data_entry,
    input  logic                      multi_frame_receive_mode,
    input  logic                      error_flags_stored,
    input  logic                      tx_start,
    input  logic                      emd_suppress,
    // receive decoder events
    input  irqef_pkg::irqef_rx_ev_type rx_ev,
    output logic                      rx_byte_push,
    output logic                      rx_stop,
    output logic                      rx_frame_drop,
    output logic                      receive_done_request,
    // interrupt
    output logic                      combined_int_flag,
    output logic                      error_request_flag,
    output irqef_pkg::irqef_pin_type  int_pin
);

    // ******************************************************
    // registers
    // ******************************************************
    logic [7:0] ena1_q;
    logic [7:0] ena1_d;
    logic [7:0] ena0_q;
    logic [7:0] ena0_d;
    logic [5:0] req1_q;
    logic [5:0] req1_d;
    logic [7:0] err_q;
    logic [7:0] err_d;
    logic [7:0] coll_q;
    logic [7:0] coll_d;
    logic       coll_err_q;
    logic       coll_err_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       fifo_push_q;
    logic       rx_push_q;
    logic       rx_stop_q;
    logic       drop_q;
    logic       done_q;
    logic       comb_q;
    logic       err_req_q;
    irqef_pkg::irqef_pin_type pin_q;
    irqef_pkg::irqef_pin_type pin_d;

    // ******************************************************
    // address decode
    // ******************************************************
    wire wr_ena1 = reg_wr && (reg_addr == irqef_pkg::ADDR_ENA_GROUP1);
    wire wr_ena0 = reg_wr && (reg_addr == irqef_pkg::ADDR_ENA_GROUP0);
    wire wr_req1 = reg_wr && (reg_addr == irqef_pkg::ADDR_REQ_GROUP1);
    wire wr_rxb  = reg_wr && (reg_addr == irqef_pkg::ADDR_RX_BIT_CTRL);

    // ******************************************************
    // enable registers
    // ******************************************************
    assign ena1_d = wr_ena1 ? reg_wdata : ena1_q;
    assign ena0_d = wr_ena0 ? reg_wdata : ena0_q;
    assign coll_err_d = wr_rxb ? reg_wdata[irqef_pkg::RXB_COLL_ERR] : coll_err_q;

    // ******************************************************
    // request group 1: timers and card detect
    // ******************************************************
    // set mode bit chooses whether written ones set or clear
    wire       req_set_mode = reg_wdata[irqef_pkg::REQ1_SET_MODE];
    wire [5:0] req_host_set = (wr_req1 && req_set_mode) ? reg_wdata[5:0] : 6'h00;
    wire [5:0] req_host_clr = (wr_req1 && !req_set_mode) ? reg_wdata[5:0] : 6'h00;
    wire [5:0] req_hw_set   = {card_detect_event, tmr_underflow};
    // hardware set wins over a host clear in the same cycle
    assign req1_d = (req1_q & ~req_host_clr) | req_host_set | req_hw_set;

    // ******************************************************
    // fifo misuse
    // ******************************************************
    wire busy_rx_state = (com_state == irqef_pkg::COM_RX_WAIT)
                      || (com_state == irqef_pkg::COM_WAIT_DATA)
                      || (com_state == irqef_pkg::COM_RECEIVING);
    wire fifo_wr_bad   = host_fifo_wr && (crc_tx_active || busy_rx_state || auth_active);
    wire fifo_wr_clr   = multi_frame_receive_mode ? error_flags_stored : cl_cmd_start;
    wire ovf_set       = host_fifo_wr && fifo_full;
    // once overflowed every later write is dropped until fifo_flush, contents kept
    wire fifo_accept   = host_fifo_wr && !fifo_full && !err_q[irqef_pkg::ERR_FIFO_OVF];

    // ******************************************************
    // receive frame checks
    // ******************************************************
    wire short_bits  = rx_ev.frame_end && (rx_ev.bit_count < irqef_pkg::MIN_FRAME_BITS);
    wire short_emd   = rx_ev.frame_end && emd_suppress
                    && (rx_ev.byte_count < irqef_pkg::MIN_EMD_BYTES);
    wire short_set   = short_bits && rx_ev.sof_valid;
    wire frame_drop  = short_bits || short_emd;
    wire frame_done  = rx_ev.frame_end && !frame_drop;
    wire coll_hit    = rx_ev.collision && !rx_ev.collision_in_eof;
    wire prot_set    = rx_ev.bad_stop_bit || rx_ev.bad_sof_eof || rx_ev.bad_byte_count;
    wire integ_set   = rx_ev.parity_error || rx_ev.crc_error
                    || (coll_hit && coll_err_q);
    wire rx_clr      = rx_cmd_start || wait_data_entry;
    wire first_coll  = coll_hit && !err_q[irqef_pkg::ERR_COLLISION];
    wire byte_push   = rx_ev.byte_valid && !prot_set;

    // ******************************************************
    // error flags: set wins over clear for every bit
    // ******************************************************
    wire [7:0] err_set;
    wire [7:0] err_clr;
    assign err_set[irqef_pkg::ERR_NVM]         = nvm_cmd_done && nvm_cmd_error;
    assign err_clr[irqef_pkg::ERR_NVM]         = nvm_cmd_done;
    assign err_set[irqef_pkg::ERR_FIFO_WR]     = fifo_wr_bad;
    assign err_clr[irqef_pkg::ERR_FIFO_WR]     = fifo_wr_clr;
    assign err_set[irqef_pkg::ERR_FIFO_OVF]    = ovf_set;
    assign err_clr[irqef_pkg::ERR_FIFO_OVF]    = fifo_flush;
    assign err_set[irqef_pkg::ERR_SHORT_FRAME] = short_set;
    assign err_clr[irqef_pkg::ERR_SHORT_FRAME] = rx_clr;
    assign err_set[irqef_pkg::ERR_EMPTY_TX]    = tx_start && fifo_empty;
    assign err_clr[irqef_pkg::ERR_EMPTY_TX]    = cl_cmd_start;
    assign err_set[irqef_pkg::ERR_COLLISION]   = coll_hit;
    assign err_clr[irqef_pkg::ERR_COLLISION]   = rx_clr;
    assign err_set[irqef_pkg::ERR_PROTOCOL]    = prot_set;
    assign err_clr[irqef_pkg::ERR_PROTOCOL]    = rx_clr;
    assign err_set[irqef_pkg::ERR_INTEGRITY]   = integ_set;
    assign err_clr[irqef_pkg::ERR_INTEGRITY]   = rx_clr;
    assign err_d = (err_q & ~err_clr) | err_set;

    // collision position: first one of the frame only
    wire [7:0] coll_new = {rx_ev.collision_pos_in_range, rx_ev.collision_pos};
    assign coll_d = first_coll ? coll_new : (rx_clr ? irqef_pkg::RST_BYTE : coll_q);

    // ******************************************************
    // combined interrupt and pin
    // ******************************************************
    wire err_req_d = err_d[irqef_pkg::ERR_FIFO_WR] || err_d[irqef_pkg::ERR_FIFO_OVF]
                  || err_d[irqef_pkg::ERR_PROTOCOL] || err_d[irqef_pkg::ERR_EMPTY_TX]
                  || err_d[irqef_pkg::ERR_INTEGRITY];
    wire [4:0] tmr_gated = req1_q[4:0] & ena1_q[irqef_pkg::ENA1_TMR_TOP:0];
    wire card_gated = req1_q[irqef_pkg::REQ1_CARD_DET]
                   && ena1_q[irqef_pkg::ENA1_CARD_DET];
    wire errq_gated = err_req_q && ena0_q[irqef_pkg::ENA0_ERR_REQ];
    wire comb_d     = (|tmr_gated) || card_gated || errq_gated;
    // pin follows the registered combined flag, so it lags it by one cycle
    wire pin_active = comb_q && ena1_q[irqef_pkg::ENA1_PIN_EN];
    wire pin_level  = pin_active ^ ena0_q[irqef_pkg::ENA0_INVERT];
    wire push_pull  = ena1_q[irqef_pkg::ENA1_PUSH_PULL];
    // open-drain pulls low for a low level and releases for a high one
    assign pin_d.level = pin_level;
    assign pin_d.out   = push_pull ? pin_level : 1'b0;
    assign pin_d.oe    = push_pull ? 1'b1 : !pin_level;

    // ******************************************************
    // read path: data only in the cycle after the strobe
    // ******************************************************
    wire [7:0] req1_view = {1'b0, comb_q, req1_q};
    wire [7:0] rxb_view  = {4'h0, coll_err_q, 3'h0};
    wire [7:0] rd_sel =
        (reg_addr == irqef_pkg::ADDR_ENA_GROUP1)  ? ena1_q    :
        (reg_addr == irqef_pkg::ADDR_ENA_GROUP0)  ? ena0_q    :
        (reg_addr == irqef_pkg::ADDR_REQ_GROUP1)  ? req1_view :
        (reg_addr == irqef_pkg::ADDR_ERR_FLAGS)   ? err_q     :
        (reg_addr == irqef_pkg::ADDR_RX_BIT_CTRL) ? rxb_view  :
        (reg_addr == irqef_pkg::ADDR_COLL_POS)    ? coll_q    :
                                                    irqef_pkg::RST_BYTE;
    assign rdata_d = reg_rd ? rd_sel : irqef_pkg::RST_BYTE;

    // ******************************************************
    // flip-flops
    // ******************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ena1_q     <= irqef_pkg::RST_BYTE;
            ena0_q     <= irqef_pkg::RST_BYTE;
            req1_q     <= 6'h00;
            err_q      <= irqef_pkg::RST_BYTE;
            coll_q     <= irqef_pkg::RST_BYTE;
            coll_err_q <= 1'b0;
            rdata_q    <= irqef_pkg::RST_BYTE;
        end else begin
            ena1_q     <= ena1_d;
            ena0_q     <= ena0_d;
            req1_q     <= req1_d;
            err_q      <= err_d;
            coll_q     <= coll_d;
            coll_err_q <= coll_err_d;
            rdata_q    <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fifo_push_q <= 1'b0;
            rx_push_q   <= 1'b0;
            rx_stop_q   <= 1'b0;
            drop_q      <= 1'b0;
            done_q      <= 1'b0;
            comb_q      <= 1'b0;
            err_req_q   <= 1'b0;
            pin_q       <= '0;
        end else begin
            fifo_push_q <= fifo_accept;
            rx_push_q   <= byte_push;
            rx_stop_q   <= prot_set;
            drop_q      <= frame_drop;
            done_q      <= frame_done;
            comb_q      <= comb_d;
            err_req_q   <= err_req_d;
            pin_q       <= pin_d;
        end
    end

    // ******************************************************
    // outputs
    // ******************************************************
    assign reg_rdata            = rdata_q;
    assign fifo_push            = fifo_push_q;
    assign rx_byte_push         = rx_push_q;
    assign rx_stop              = rx_stop_q;
    assign rx_frame_drop        = drop_q;
    assign receive_done_request = done_q;
    assign combined_int_flag    = comb_q;
    assign error_request_flag   = err_req_q;
    assign int_pin              = pin_q;

endmodule : irqef_top

// ===== shared/irqef_pkg.sv
// package: offsets, field positions, reset values and carrier types of the irq/error block
package irqef_pkg;

    // ******************************************************
    // register addresses (host port, byte addresses)
    // ******************************************************
    localparam logic [7:0] ADDR_REQ_GROUP1  = 8'h07;
    localparam logic [7:0] ADDR_ENA_GROUP0  = 8'h08;
    localparam logic [7:0] ADDR_ENA_GROUP1  = 8'h09;
    localparam logic [7:0] ADDR_ERR_FLAGS   = 8'h0a;
    localparam logic [7:0] ADDR_RX_BIT_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_COLL_POS    = 8'h0d;

    // ******************************************************
    // field positions
    // ******************************************************
    localparam int ENA1_PUSH_PULL  = 7;
    localparam int ENA1_PIN_EN     = 6;
    localparam int ENA1_CARD_DET   = 5;
    localparam int ENA1_TMR_TOP    = 4;
    localparam int ENA0_INVERT     = 7;
    localparam int ENA0_ERR_REQ    = 1;
    localparam int REQ1_SET_MODE   = 7;
    localparam int REQ1_COMBINED   = 6;
    localparam int REQ1_CARD_DET   = 5;
    localparam int ERR_NVM         = 7;
    localparam int ERR_FIFO_WR     = 6;
    localparam int ERR_FIFO_OVF    = 5;
    localparam int ERR_SHORT_FRAME = 4;
    localparam int ERR_EMPTY_TX    = 3;
    localparam int ERR_COLLISION   = 2;
    localparam int ERR_PROTOCOL    = 1;
    localparam int ERR_INTEGRITY   = 0;
    localparam int RXB_COLL_ERR    = 3;
    localparam int COLL_VALID      = 7;
    localparam int NUM_TIMERS      = 5;

    // ******************************************************
    // reset values and limits
    // ******************************************************
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] MIN_FRAME_BITS  = 8'h04;
    localparam logic [7:0] MIN_EMD_BYTES   = 8'h03;

    // transmitter/receiver state codes
    localparam logic [2:0] COM_RX_WAIT     = 3'h5;
    localparam logic [2:0] COM_WAIT_DATA   = 3'h6;
    localparam logic [2:0] COM_RECEIVING   = 3'h7;

    // ******************************************************
    // carrier types
    // ******************************************************
    typedef struct packed {
        logic       sof_valid;
        logic       frame_end;
        logic [7:0] bit_count;
        logic [7:0] byte_count;
        logic       byte_valid;
        logic       collision;
        logic       collision_in_eof;
        logic [6:0] collision_pos;
        logic       collision_pos_in_range;
        logic       bad_stop_bit;
        logic       bad_sof_eof;
        logic       bad_byte_count;
        logic       parity_error;
        logic       crc_error;
    } irqef_rx_ev_type;

    typedef struct packed {
        logic       level;
        logic       out;
        logic       oe;
    } irqef_pin_type;

endpackage : irqef_pkg

// ===== bench/irqef_properties.sv
// checker: port-level properties of the irq enable and error flag block
`timescale 1ns/1ps
module irqef_properties (
    input logic                       clk_sys,
    input logic                       reset_n,
    input logic [7:0]                 reg_addr,
    input logic [7:0]                 reg_wdata,
    input logic                       reg_wr,
    input logic                       reg_rd,
    input logic [7:0]                 reg_rdata,
    input logic [4:0]                 tmr_underflow,
    input logic                       card_detect_event,
    input logic                       host_fifo_wr,
    input logic                       fifo_full,
    input logic                       fifo_push,
    input irqef_pkg::irqef_rx_ev_type rx_ev,
    input logic                       rx_byte_push,
    input logic                       rx_stop,
    input logic                       rx_frame_drop,
    input logic                       receive_done_request,
    input logic                       combined_int_flag,
    input logic                       error_request_flag,
    input irqef_pkg::irqef_pin_type   int_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // shadow enables; quiet_q says they have settled into the pin path
    logic [7:0] ena1_q, ena1_d, ena0_q, ena0_d;
    logic [1:0] quiet_q, quiet_d;
    wire a09  = reg_addr == irqef_pkg::ADDR_ENA_GROUP1;
    wire a08  = reg_addr == irqef_pkg::ADDR_ENA_GROUP0;
    wire prot = rx_ev.bad_stop_bit || rx_ev.bad_sof_eof || rx_ev.bad_byte_count;
    assign ena1_d  = (reg_wr && a09) ? reg_wdata : ena1_q;
    assign ena0_d  = (reg_wr && a08) ? reg_wdata : ena0_q;
    assign quiet_d = (reg_wr && (a08 || a09)) ? 2'h0 : (quiet_q == 2'h3) ? 2'h3 : quiet_q + 2'h1;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ena1_q  <= 8'h00;
            ena0_q  <= 8'h00;
            quiet_q <= 2'h0;
        end else begin
            ena1_q  <= ena1_d;
            ena0_q  <= ena0_d;
            quiet_q <= quiet_d;
        end
    end
    sequence s_ena_wr_rd;
        reg_wr && a09 ##1 reg_rd && a09;
    endsequence
    sequence s_src_quiet;
        quiet_q == 2'h3 && |({card_detect_event, tmr_underflow} & ena1_q[5:0]) && !reg_wr
            ##1 !reg_wr;
    endsequence
    a_drive_style: assert property (quiet_q == 2'h3 |-> (ena1_q[7] ? (int_pin.oe && int_pin.out == int_pin.level) : (!int_pin.out && int_pin.oe == !int_pin.level)))
        else $error("pin drive style wrong");
    a_pin_gate: assert property (quiet_q == 2'h3 && !ena1_q[6] && !ena0_q[7] |-> !int_pin.level)
        else $error("pin active while disabled");
    a_pin_follow: assert property (quiet_q == 2'h3 && ena1_q[6] |-> int_pin.level == ($past(combined_int_flag) ^ ena0_q[7]))
        else $error("pin does not follow combined flag");
    a_src_gate: assert property (s_src_quiet |=> combined_int_flag)
        else $error("enabled request missed combined flag");
    a_ovf_discard: assert property (host_fifo_wr && fifo_full |=> !fifo_push)
        else $error("write to full fifo accepted");
    a_err_request: assert property ((host_fifo_wr && fifo_full) || rx_ev.parity_error |-> ##2 error_request_flag)
        else $error("error request not raised");
    a_prot_stop: assert property (prot |=> rx_stop)
        else $error("reception not stopped");
    a_prot_nopush: assert property (prot && rx_ev.byte_valid |=> !rx_byte_push)
        else $error("byte pushed at protocol fault");
    a_short_drop: assert property (rx_ev.frame_end && rx_ev.sof_valid && rx_ev.bit_count < irqef_pkg::MIN_FRAME_BITS |=> rx_frame_drop && !receive_done_request)
        else $error("short frame not dropped");
    a_ena_readback: assert property (s_ena_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
        else $error("enable readback wrong");
endmodule : irqef_properties
bind irqef_top irqef_properties u_props (.*);

// ===== bench/irqef_host_pin.sv
// partner: host input of the interrupt line with its pull-up
`timescale 1ns/1ps
module irqef_host_pin (
    input irqef_pkg::irqef_pin_type int_pin,
    output logic                    pin_wire
);
    // a released open-drain line is pulled high, never left at its last value
    assign pin_wire = int_pin.oe ? int_pin.out : 1'b1;
endmodule : irqef_host_pin

// ===== bench/irqef_top_tb.sv
// testbench: enables, interrupt pin and error flags of the irq block
`timescale 1ns/1ps
module irqef_top_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, r;
    logic [4:0] tmr_underflow = 5'h00;
    logic card_detect_event = 1'b0, nvm_cmd_done = 1'b0, nvm_cmd_error = 1'b0;
    logic host_fifo_wr = 1'b0, fifo_full = 1'b0, fifo_empty = 1'b0, fifo_flush = 1'b0;
    logic [2:0] com_state = 3'h0;
    logic crc_tx_active = 1'b0, auth_active = 1'b0, cl_cmd_start = 1'b0, rx_cmd_start = 1'b0;
    logic wait_data_entry = 1'b0, multi_frame_receive_mode = 1'b0, error_flags_stored = 1'b0;
    logic tx_start = 1'b0, emd_suppress = 1'b0, fifo_push, rx_byte_push, rx_stop, pin_wire;
    logic rx_frame_drop, receive_done_request, combined_int_flag, error_request_flag;
    logic [6:0] p;
    irqef_pkg::irqef_rx_ev_type rx_ev = '0, ev;
    irqef_pkg::irqef_pin_type   int_pin;
    logic [7:0] exp_q[$];
    int miscompares = 0, checks_done = 0, cycles = 0, m, seed;
    irqef_top dut (.*);
    irqef_host_pin host (.int_pin(int_pin), .pin_wire(pin_wire));
    always #20 clk_sys = ~clk_sys;
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        reg_rd <= 1'b1;
        exp_q.push_back(d);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : wr_rd
    task automatic src(input logic [5:0] v);
        @(posedge clk_sys);
        {card_detect_event, tmr_underflow} <= v;
        @(posedge clk_sys);
        {card_detect_event, tmr_underflow} <= 6'h00;
    endtask : src
    task automatic rx(input irqef_pkg::irqef_rx_ev_type e);
        @(posedge clk_sys);
        rx_ev <= e;
        @(posedge clk_sys);
        rx_ev <= '0;
    endtask : rx
    // ****************************************
    // read monitor and hang guard
    // ****************************************
    always @(posedge clk_sys) begin
        if (rd_pend) begin
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
        rd_pend <= reg_rd;
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = $urandom(81279);
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        wr(8'h0a, 8'hff);
        wr(8'h3f, 8'hff);
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h3f, 8'h00);
        $display("test reset done");
        r = 8'($urandom);
        wr_rd(8'h09, r);
        for (int n = 0; n < 6; n++) begin
            m = (n + 1) % 6;
            wr(8'h09, 8'h40 | (8'(n[0]) << 7) | (8'h01 << n));
            src(6'h01 << m);
            repeat (3) @(posedge clk_sys);
            chk("combined_int_flag", 8'h00, {7'h0, combined_int_flag});
            src(6'h01 << n);
            repeat (3) @(posedge clk_sys);
            chk("pin_wire", 8'h01, {7'h0, pin_wire});
            chk("int_pin.oe", 8'(n[0]), {7'h0, int_pin.oe});
            rd(8'h07, 8'h40 | (8'h01 << n) | (8'h01 << m));
            wr(8'h07, 8'h3f);
            repeat (3) @(posedge clk_sys);
            chk("pin_wire", 8'h00, {7'h0, pin_wire});
        end
        wr(8'h09, 8'h01);
        src(6'h01);
        repeat (3) @(posedge clk_sys);
        chk("int_pin", 8'h00, {7'h0, int_pin.level});
        wr(8'h09, 8'h40);
        wr(8'h08, 8'h80);
        repeat (4) @(posedge clk_sys);
        chk("int_pin", 8'h01, {7'h0, int_pin.level});
        wr(8'h08, 8'h00);
        wr(8'h07, 8'h3f);
        $display("test enables done");
        for (int i = 0; i < 5; i++) begin
            com_state     <= (i < 3) ? irqef_pkg::COM_RX_WAIT + 3'(i) : 3'h0;
            crc_tx_active <= (i == 3);
            auth_active   <= (i == 4);
            @(posedge clk_sys) host_fifo_wr <= 1'b1;
            @(posedge clk_sys) host_fifo_wr <= 1'b0;
            @(posedge clk_sys) chk("fifo_push", 8'h01, {7'h0, fifo_push});
            rd(8'h0a, 8'h40);
            @(posedge clk_sys) cl_cmd_start <= 1'b1;
            @(posedge clk_sys) cl_cmd_start <= 1'b0;
            rd(8'h0a, 8'h00);
        end
        {com_state, multi_frame_receive_mode} <= {irqef_pkg::COM_RX_WAIT, 1'b1};
        @(posedge clk_sys) {host_fifo_wr, cl_cmd_start} <= 2'h3;
        @(posedge clk_sys) {host_fifo_wr, cl_cmd_start} <= 2'h0;
        rd(8'h0a, 8'h40);
        @(posedge clk_sys) error_flags_stored <= 1'b1;
        @(posedge clk_sys) {error_flags_stored, multi_frame_receive_mode} <= 2'h0;
        rd(8'h0a, 8'h00);
        {com_state, crc_tx_active, auth_active, fifo_full} <= 6'h01;
        @(posedge clk_sys) host_fifo_wr <= 1'b1;
        @(posedge clk_sys) fifo_full <= 1'b0;
        @(posedge clk_sys) host_fifo_wr <= 1'b0;
        @(posedge clk_sys) chk("fifo_push", 8'h00, {7'h0, fifo_push});
        rd(8'h0a, 8'h20);
        chk("error_request_flag", 8'h01, {7'h0, error_request_flag});
        @(posedge clk_sys) fifo_flush <= 1'b1;
        @(posedge clk_sys) {fifo_flush, fifo_full, nvm_cmd_error, nvm_cmd_done} <= 4'h3;
        @(posedge clk_sys) {nvm_cmd_error, nvm_cmd_done} <= 2'h0;
        rd(8'h0a, 8'h80);
        @(posedge clk_sys) {fifo_empty, nvm_cmd_done, tx_start} <= 3'h7;
        @(posedge clk_sys) {fifo_empty, nvm_cmd_done, tx_start} <= 3'h0;
        rd(8'h0a, 8'h08);
        @(posedge clk_sys) cl_cmd_start <= 1'b1;
        @(posedge clk_sys) cl_cmd_start <= 1'b0;
        $display("test fifo and nvm done");
        p = 7'($urandom);
        ev = '0;
        ev.collision = 1'b1;
        ev.collision_in_eof = 1'b1;
        rx(ev);
        rd(8'h0a, 8'h00);
        ev.collision_in_eof = 1'b0;
        ev.collision_pos = p;
        ev.collision_pos_in_range = 1'b1;
        rx(ev);
        ev.collision_pos = ~p;
        rx(ev);
        ev = '0;
        ev.parity_error = 1'b1;
        rx(ev);
        ev = '0;
        {ev.bad_stop_bit, ev.byte_valid} = 2'h3;
        rx(ev);
        ev = '0;
        {ev.frame_end, ev.sof_valid, ev.bit_count} = {2'h3, 8'h03};
        rx(ev);
        rd(8'h0a, 8'h17);
        rd(8'h0d, {1'b1, p});
        @(posedge clk_sys) wait_data_entry <= 1'b1;
        @(posedge clk_sys) wait_data_entry <= 1'b0;
        rd(8'h0a, 8'h00);
        rd(8'h0d, 8'h00);
        ev = '0;
        {ev.frame_end, ev.byte_valid, ev.bit_count, ev.byte_count} = {2'h3, 8'h08, 8'h02};
        rx(ev);
        @(posedge clk_sys);
        chk("rx_done", 8'h03, {6'h0, receive_done_request, rx_byte_push});
        emd_suppress <= 1'b1;
        rx(ev);
        @(posedge clk_sys);
        chk("rx_emd_drop", 8'h01, {6'h0, receive_done_request, rx_frame_drop});
        emd_suppress <= 1'b0;
        wr(8'h0c, 8'h08);
        ev = '0;
        ev.collision = 1'b1;
        rx(ev);
        rd(8'h0a, 8'h05);
        @(posedge clk_sys) rx_cmd_start <= 1'b1;
        @(posedge clk_sys) rx_cmd_start <= 1'b0;
        rd(8'h0a, 8'h00);
        repeat (3) @(posedge clk_sys);
        $display("test receive errors done");
        test_done();
    end
endmodule : irqef_top_tb
